/* src/gpe_pkg.sv */
/*
 * Shared constants for the port-eight and input-only port block:
 * register byte offsets, field positions, reset values and bus codes.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
package gpe_pkg;

    // Register byte offsets
    localparam logic [11:0] OFF_DIR     = 12'h000;
    localparam logic [11:0] OFF_OUT     = 12'h004;
    localparam logic [11:0] OFF_LEVELS  = 12'h008;
    localparam logic [11:0] OFF_ANALOG  = 12'h00C;

    // Port-eight field layout
    localparam int          P8_LSB      = 5;
    localparam int          P8_PINS     = 3;
    localparam logic [4:0]  P8_RSVD_VAL = 5'h1F;

    // Reset values
    localparam logic [2:0]  DIR_RST     = 3'h0;
    localparam logic [2:0]  OUT_RST     = 3'h0;
    localparam logic [7:0]  ANALOG_RST  = 8'h00;

    // AXI response codes
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

/* src/gpe_pin_cell.sv */
/*
 * One bidirectional port pin: drive enable, output value and read-back mux.
 * Assumes the pin level is already synchronous to the system clock.
 */
module gpe_pin_cell (
    // Control
    input  wire logic dir,
    input  wire logic out_val,
    // Pin
    input  wire logic pin_i,
    output logic      pin_o,
    output logic      pin_oe,
    // Read-back
    output logic      rd_val
);

    // Drive when output, read stored or pin level
    assign pin_oe = dir;
    assign pin_o  = out_val;
    assign rd_val = dir ? out_val : pin_i;

endmodule

/* src/gpe_port.sv */
/*
 * Three-pin bidirectional port eight and eight-pin input-only port,
 * with registers reached over AXI4-Lite.
 * Assumes pin inputs and the analog selection are synchronous to aclk.
 */
// Our own choices: the AXI4-Lite slave port and the register addresses.
module gpe_port #(
    parameter int IN_PINS = 8
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Port-eight pins seven down to five
    input  wire logic [2:0]  port_eight_pin_i,
    output logic [2:0]       port_eight_pin_o,
    output logic [2:0]       port_eight_pin_oe,
    // Input-only port pins
    input  wire logic [7:0]  input_port_pins
);

    if (IN_PINS != 8) begin : g_chk
        $error("gpe_port: IN_PINS must be 8");
    end

    logic [2:0]  port_eight_direction_q;
    logic [2:0]  port_eight_output_data_q;
    logic [7:0]  analog_select_q;
    logic [2:0]  rd_p8;
    logic [7:0]  input_port_levels;
    logic [11:0] aw_q;
    logic        aw_have_q;
    logic [31:0] w_q;
    logic [3:0]  ws_q;
    logic        w_have_q;
    logic        wr_go;
    logic        wr_hit;
    logic        rd_hit;
    logic [31:0] rd_word;

    // Per-pin direction, drive and read-back
    for (genvar i = 0; i < gpe_pkg::P8_PINS; i++) begin : g_pin
        gpe_pin_cell u_cell (
            .dir     (port_eight_direction_q[i]),
            .out_val (port_eight_output_data_q[i]),
            .pin_i   (port_eight_pin_i[i]),
            .pin_o   (port_eight_pin_o[i]),
            .pin_oe  (port_eight_pin_oe[i]),
            .rd_val  (rd_p8[i])
        );
    end

    // Input-only pins: no drive exists, analog channels masked
    assign input_port_levels = input_port_pins & ~analog_select_q;

    // Address and data may arrive in either order
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
    assign wr_go         = aw_have_q && w_have_q;

    // Capture write address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            aw_q      <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_q      <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_have_q <= 1'b0;
        end
    end

    // Capture write data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            w_q      <= 32'h0000_0000;
            ws_q     <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_q      <= s_axi_wdata;
            ws_q     <= s_axi_wstrb;
        end else if (wr_go) begin
            w_have_q <= 1'b0;
        end
    end

    // Write decode
    always_comb begin
        wr_hit = (aw_q[11:2] == gpe_pkg::OFF_DIR[11:2])
              || (aw_q[11:2] == gpe_pkg::OFF_OUT[11:2])
              || (aw_q[11:2] == gpe_pkg::OFF_ANALOG[11:2]);
    end

    // Direction register, low byte lane only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_eight_direction_q <= gpe_pkg::DIR_RST;
        end else if (wr_go && ws_q[0] && aw_q[11:2] == gpe_pkg::OFF_DIR[11:2]) begin
            port_eight_direction_q <= w_q[7:5];
        end
    end

    // Output data register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_eight_output_data_q <= gpe_pkg::OUT_RST;
        end else if (wr_go && ws_q[0] && aw_q[11:2] == gpe_pkg::OFF_OUT[11:2]) begin
            port_eight_output_data_q <= w_q[7:5];
        end
    end

    // Analog channel selection register, low byte lane, written at OFF_ANALOG
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            analog_select_q <= gpe_pkg::ANALOG_RST;
        end else if (wr_go && ws_q[0] && aw_q[11:2] == gpe_pkg::OFF_ANALOG[11:2]) begin
            analog_select_q <= w_q[7:0];
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= gpe_pkg::RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? gpe_pkg::RESP_OKAY : gpe_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read mux
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (s_axi_araddr[11:2])
            gpe_pkg::OFF_DIR[11:2]: begin
                rd_word[7:5] = port_eight_direction_q;
            end
            gpe_pkg::OFF_OUT[11:2]: begin
                rd_word[7:5] = rd_p8;
                rd_word[4:0] = gpe_pkg::P8_RSVD_VAL;
            end
            gpe_pkg::OFF_LEVELS[11:2]: begin
                rd_word[7:0] = input_port_levels;
            end
            gpe_pkg::OFF_ANALOG[11:2]: begin
                rd_word[7:0] = analog_select_q;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    // Read response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= gpe_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? gpe_pkg::RESP_OKAY : gpe_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

/* tb/gpe_port_props.sv */
/* Checker on the gpe_port ports, bound below.
   Assumes write address and data are offered together. */
module gpe_port_props (
    // Clock, reset and bus
    input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire logic        s_axi_wready, s_axi_bvalid, s_axi_arvalid, s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [11:0] s_axi_awaddr, s_axi_araddr,
    input wire logic [31:0] s_axi_wdata, s_axi_rdata,
    // Pins
    input wire logic [2:0]  port_eight_pin_i, port_eight_pin_o, port_eight_pin_oe,
    input wire logic [7:0]  input_port_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wd_q;
    wire  [2:0] oe = port_eight_pin_oe, po = port_eight_pin_o, rd = s_axi_rdata[7:5];
    wire        aw = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire        ar = s_axi_arvalid && s_axi_arready;
    wire        ar_out = ar && s_axi_araddr == gpe_pkg::OFF_OUT;
    wire        ar_lvl = ar && s_axi_araddr == gpe_pkg::OFF_LEVELS;
    // Data of the write just taken
    always_ff @(posedge aclk) begin
        if (aw) wd_q <= s_axi_wdata[7:5];
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_rst_inputs: assert property ($rose(aresetn) |-> {oe, po} == 6'h00)
        else $error("pins after reset");
    a_dir_drive: assert property (aw && s_axi_awaddr == gpe_pkg::OFF_DIR |=>
        ##[0:2] oe == wd_q) else $error("enable");
    a_out_drive: assert property (aw && s_axi_awaddr == gpe_pkg::OFF_OUT |=>
        ##[0:2] po == wd_q) else $error("output pin");
    a_oe_cause: assert property ($changed(oe) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("enable moved");
    a_rd_stored: assert property (ar_out |=>
        s_axi_rvalid && ((rd ^ $past(po)) & $past(oe)) == 3'h0) else $error("stored bit");
    a_rd_pin: assert property (ar_out |=>
        ((rd ^ $past(port_eight_pin_i)) & ~$past(oe)) == 3'h0) else $error("pin bit");
    a_rd_rsvd: assert property (ar_out |=> s_axi_rdata[4:0] == gpe_pkg::P8_RSVD_VAL)
        else $error("reserved");
    a_lvl_mask: assert property (ar_lvl |=>
        (s_axi_rdata[7:0] & ~$past(input_port_pins)) == 8'h00) else $error("levels");
    c_dir: cover property (aw && s_axi_awaddr == gpe_pkg::OFF_DIR);
    c_out: cover property (ar_out);
    c_lvl: cover property (ar_lvl);
endmodule
bind gpe_port gpe_port_props u_props (.*);

/* tb/gpe_board.sv */
/* Board model on the port-eight pads.
   Assumes the bench sets the board levels. */
module gpe_board (
    // Pad drive and board level
    input wire logic [2:0] pin_o, pin_oe, lvl,
    // Pad level back to the block
    output logic [2:0]     pin_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // Block wins where it drives
    assign pin_i = pin_o & pin_oe | lvl & ~pin_oe;
endmodule

/* tb/testbench.sv */
/* Bench for gpe_port: bus tasks, integer model, board on the pins.
   Assumes the checker binds itself. */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic s_axi_bready = 1, s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, got;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic [2:0] port_eight_pin_i, port_eight_pin_o, port_eight_pin_oe, lvl = 0;
    logic [7:0] input_port_pins = 0;
    int fail_count = 0, checks = 0, m_dir = 0, m_out = 0, m_sel = 0;
    integer seed = 46;
    gpe_port dut (.*);
    gpe_board board (.pin_o(port_eight_pin_o), .pin_oe(port_eight_pin_oe), .lvl(lvl),
        .pin_i(port_eight_pin_i));
    // Clock at 4 ns
    always #2 aclk = ~aclk;
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= '1;
        s_axi_wvalid <= '1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= '0;
            if (s_axi_wready) s_axi_wvalid <= '0;
        end while (s_axi_bvalid !== '1);
        chk("bresp", 32'(r), 32'(s_axi_bresp));
    endtask
    task automatic rd(logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= '1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= '0;
        end while (s_axi_rvalid !== '1);
        got = s_axi_rdata;
    endtask
    // Both ports against the model
    task automatic chk_port;
        rd(gpe_pkg::OFF_OUT);
        chk("out", 32'((m_dir & m_out | ~m_dir & lvl) * 32 & 224 | 31), got);
        chk("out rresp", 32'(gpe_pkg::RESP_OKAY), 32'(s_axi_rresp));
        rd(gpe_pkg::OFF_LEVELS);
        chk("levels", 32'(input_port_pins & ~m_sel & 255), got);
        chk("levels rresp", 32'(gpe_pkg::RESP_OKAY), 32'(s_axi_rresp));
        rd(gpe_pkg::OFF_DIR);
        chk("dir", 32'(m_dir * 32), got);
        rd(gpe_pkg::OFF_ANALOG);
        chk("analog", 32'(m_sel), got);
        chk("oe", 32'(m_dir), 32'(port_eight_pin_oe));
        chk("pin_o", 32'(m_out), 32'(port_eight_pin_o));
    endtask
    task automatic give_verdict;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Watchdog well past the run length
    initial begin
        repeat (5000) @(posedge aclk);
        fail_count++;
        give_verdict();
    end
    // Reset, random setups, then an unmapped write
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= '1;
        for (int i = 0; i < 9; i++) begin
            @(posedge aclk);
            lvl <= 3'($random(seed));
            input_port_pins <= 8'($random(seed));
            if (i > 0) begin
                m_dir = $random(seed) & 7;
                m_out = $random(seed) & 7;
                m_sel = $random(seed) & 255;
                wr(gpe_pkg::OFF_DIR, 32'(m_dir * 32), gpe_pkg::RESP_OKAY);
                wr(gpe_pkg::OFF_OUT, 32'(m_out * 32), gpe_pkg::RESP_OKAY);
                wr(gpe_pkg::OFF_ANALOG, 32'(m_sel), gpe_pkg::RESP_OKAY);
            end
            chk_port();
            $display("test %0d done", i);
        end
        wr(12'h010, '1, gpe_pkg::RESP_SLVERR);
        chk_port();
        rd(12'h010);
        chk("unmapped rdata", 32'h0000_0000, got);
        chk("unmapped rresp", 32'(gpe_pkg::RESP_SLVERR), 32'(s_axi_rresp));
        give_verdict();
    end
endmodule
